// [verilog/dtcd_params.svh]
`ifndef DTCD_PARAMS_SVH
`define DTCD_PARAMS_SVH
`define DTCD_OFF_PCC 8'h00
`define DTCD_OFF_DCC 8'h04
`define DTCD_OFF_DIE1 8'h08
`define DTCD_OFF_DIE2 8'h0c
`define DTCD_OFF_PIE1 8'h10
`define DTCD_OFF_PIE2 8'h14
`define DTCD_OFF_PWR 8'h18
`define DTCD_OFF_SYS 8'h1c
`define DTCD_OFF_PMUX 8'h20
`define DTCD_OFF_STAT 8'h24
`define DTCD_PCC_DSP_CORE_DIVIDER 0
`define DTCD_PCC_MMDIV 2
`define DTCD_PCC_TRAFFIC_CTRL_DIVIDER 4
`define DTCD_PCC_DISPDIV 6
`define DTCD_PCC_COREEN 8
`define DTCD_PCC_IRQSEL 9
`define DTCD_PCC_BYPASS 10
`define DTCD_DCC_PIN_IO_DIVIDER 0
`define DTCD_DCC_PERDIV 2
`define DTCD_DCC_PIN_IO_SOURCE_SELECT 4
`define DTCD_DCC_TIMXO 5
`define DTCD_DIE1_PUB 0
`define DTCD_DIE1_TIM 1
`define DTCD_DIE1_WD 2
`define DTCD_DIE2_GPIO 0
`define DTCD_DIE2_PUB 1
`define DTCD_DIE2_TIM 2
`define DTCD_DIE2_WD 3
`define DTCD_PIE1_IF 0
`define DTCD_PIE1_LB 1
`define DTCD_PIE1_HP 2
`define DTCD_PIE1_DISP 3
`define DTCD_PIE2_LB 0
`define DTCD_PIE2_DMA 1
`define DTCD_PIE2_DISP 2
`define DTCD_PWR_LP 1
`define DTCD_PMUX_LSB 12
`define DTCD_PMUX_LP 3'h1
`define DTCD_SCHEME_SYNC 3'h0
`define DTCD_SCHEME_SCALABLE 3'h2
`define DTCD_RST_PCC 16'h0500
`define DTCD_RST_DCC 16'h0000
`define DTCD_RST_DIE1 16'h0000
`define DTCD_RST_DIE2 16'h0000
`define DTCD_RST_PIE1 16'h0000
`define DTCD_RST_PIE2 16'h0000
`define DTCD_RST_PWR 16'h0000
`define DTCD_RST_PMUX 16'h0000
`define DTCD_WD_DIVIDE 14
`define DTCD_WD_HALF 3'h6
`define DTCD_CLK_MHZ 10
`define DTCD_GLOBAL_RESET_NS 1600
`define DTCD_GLOBAL_RESET_CYC ((`DTCD_GLOBAL_RESET_NS * `DTCD_CLK_MHZ) / 1000)
`endif

// [verilog/dtcd_pkg.sv]
package dtcd_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dtcd_bus_req_t;
   typedef struct packed {
      logic out;
      logic oe;
   } dtcd_ball_t;
   typedef enum logic [2:0] {
      DTCD_RUN = 3'h1,
      DTCD_STOP = 3'h2,
      DTCD_APPLY = 3'h4
   } dtcd_div_state_t;
endpackage : dtcd_pkg

// [verilog/dtcd_gate.sv]
`timescale 1ns/100ps
`default_nettype none
module dtcd_gate
#(parameter int N = 13)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [N-1:0] clk_in,
   input wire logic [N-1:0] en,
   output logic [N-1:0] clk_out
);
   logic [N-1:0] en_q;
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_cell
         // latch-style: enable only moves while the clock is low
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               en_q[i] <= 1'b1;
            else if (!clk_in[i])
               en_q[i] <= en[i];
         end
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               clk_out[i] <= 1'b0;
            else
               clk_out[i] <= clk_in[i] & en_q[i];
         end
         property p_gate_low_only;
            @(posedge mclk) disable iff (rst)
            $changed(en_q[i]) |-> !$past(clk_in[i]);
         endproperty
         a_gate_low_only: assert property (p_gate_low_only)
            else $error("gate enable moved while clock high");
      end
   endgenerate
endmodule : dtcd_gate
`default_nettype wire

// [verilog/dtcd_divider.sv]
`timescale 1ns/100ps
`default_nettype none
module dtcd_divider
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic src,
   input wire logic [1:0] ratio_req,
   output logic clk_out,
   output logic [1:0] ratio_cur,
   output logic busy
);
   dtcd_pkg::dtcd_div_state_t state_reg;
   logic src_q;
   logic [2:0] cnt_reg;
   logic en_q;
   logic [3:0] taps;
   logic tap_sel;
   logic rise;

   assign rise = src & ~src_q;
   assign taps = {cnt_reg, src};
   assign tap_sel = taps[ratio_cur];
   assign busy = (state_reg != dtcd_pkg::DTCD_RUN);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         src_q <= 1'b0;
      else
         src_q <= src;
   end

   // free-running, never reset by ratio changes
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_reg <= 3'h0;
      else if (rise)
         cnt_reg <= cnt_reg + 3'h1;
   end

   // off, swap ratio, back on: avoids spikes on a ratio change
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= dtcd_pkg::DTCD_RUN;
         ratio_cur <= 2'h0;
         en_q <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            dtcd_pkg::DTCD_RUN:
            begin
               if (!tap_sel)
                  en_q <= 1'b1;
               if (ratio_req != ratio_cur)
                  state_reg <= dtcd_pkg::DTCD_STOP;
            end
            dtcd_pkg::DTCD_STOP:
            begin
               if (!tap_sel)
               begin
                  en_q <= 1'b0;
                  state_reg <= dtcd_pkg::DTCD_APPLY;
               end
            end
            dtcd_pkg::DTCD_APPLY:
            begin
               ratio_cur <= ratio_req;
               state_reg <= dtcd_pkg::DTCD_RUN;
            end
            default:
               state_reg <= dtcd_pkg::DTCD_RUN;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         clk_out <= 1'b0;
      else
         clk_out <= tap_sel & en_q;
   end

   sequence s_mismatch;
      state_reg == dtcd_pkg::DTCD_RUN && ratio_req != ratio_cur;
   endsequence
   property p_stop_first;
      @(posedge mclk) disable iff (rst)
      s_mismatch |=> state_reg == dtcd_pkg::DTCD_STOP;
   endproperty
   a_stop_first: assert property (p_stop_first)
      else $error("ratio change did not stop the clock first");
   property p_swap_gated;
      @(posedge mclk) disable iff (rst)
      $changed(ratio_cur) |-> !$past(en_q) && !clk_out;
   endproperty
   a_swap_gated: assert property (p_swap_gated)
      else $error("ratio swapped while clock enabled");
   property p_count;
      @(posedge mclk) disable iff (rst)
      rise |=> cnt_reg == $past(cnt_reg) + 3'h1;
   endproperty
   a_count: assert property (p_count)
      else $error("tap counter missed a source edge");
endmodule : dtcd_divider
`default_nettype wire

// [verilog/dtcd_clock_distribution.sv]
// Functional notes
// - core clock is dsp source over 1,2,4,8
// - core clock runs; stop only in dsp reset
// - memmgmt clock is dsp source over 1,2,4,8
// - pin io clock: divided source or reference, gated
// - public peripheral clock from reference, enable, idle
// - timer clock: half source or reference, gated
// - watchdog reference/14; ungateable in watchdog mode
// - pin io and peripheral dividers reset to 1
// - dsp source clock has 50 percent duty
// - source in bypass at reset; reprogram after period
// - free counter gives four 50 percent taps
// - divider resets to 1; changes stop-apply-restart
// - traffic clock divided source, idles with interface
// - irq handler uses traffic clock when selected
// - local bus clock equals traffic clock, gated
// - host port gated by own idle and dsp idle
// - dma and bridge follow interface idle; dma request
// - display clock divided traffic source, enable, idle
// - fifo bypass in synchronous scheme, used when scalable
// - low power request in deep sleep or software
// - scheme resets to 000; 010 scalable; others refused
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dtcd_params.svh"
module dtcd_clock_distribution
#(parameter int GLOBAL_RESET_CYCLES = `DTCD_GLOBAL_RESET_CYC)
(
   input wire logic mclk,
   input wire logic rst,
   input wire dtcd_pkg::dtcd_bus_req_t bus_req,
   output logic [31:0] bus_rdata,
   input wire logic reference_input_clock,
   input wire logic processor_core_clock,
   input wire logic dsp_in_reset,
   input wire logic dsp_idle,
   input wire logic watchdog_mode,
   input wire logic deep_sleep,
   output logic dsp_core_clock,
   output logic dsp_memmgmt_clock,
   output logic dsp_pin_io_clock,
   output logic dsp_public_periph_clock,
   output logic dsp_timer_clock,
   output logic dsp_watchdog_clock,
   output logic dsp_periph_clock,
   output logic traffic_ctrl_clock,
   output logic local_bus_clock,
   output logic host_port_clock,
   output logic system_dma_clock,
   output logic periph_bridge_clock,
   output logic display_ctrl_clock,
   output logic irq_handler_clock,
   output logic fifo_bypass_tc_proc,
   output logic fifo_bypass_tc_dspmm,
   output logic low_power_request,
   output dtcd_pkg::dtcd_ball_t shared_io_ball
);
   localparam int NG = 13;
   localparam int ND = 6;
   localparam int G_CORE = 0;
   localparam int G_MM = 1;
   localparam int G_GPIO = 2;
   localparam int G_PUB = 3;
   localparam int G_TIM = 4;
   localparam int G_WD = 5;
   localparam int G_PER = 6;
   localparam int G_TC = 7;
   localparam int G_LB = 8;
   localparam int G_HP = 9;
   localparam int G_DMA = 10;
   localparam int G_BR = 11;
   localparam int G_DISP = 12;
   localparam int D_CORE = 0;
   localparam int D_MM = 1;
   localparam int D_GPIO = 2;
   localparam int D_PER = 3;
   localparam int D_TC = 4;
   localparam int D_DISP = 5;

   logic [15:0] pcc_reg, dcc_reg, die1_reg, die2_reg;
   logic [15:0] pie1_reg, pie2_reg, pwr_reg, pmux_reg;
   logic [2:0] scheme_reg;
   logic [15:0] rst_cnt_reg;
   logic rst_done;
   logic dsp_pll_reg, dsp_src_reg, tr_src_reg;
   logic ref_q, ref_rise, dsp_src_q;
   logic [2:0] wd_cnt_reg;
   logic wd14_reg, tmr_half_reg;
   logic [ND-1:0] div_src, div_clk, div_busy;
   logic [1:0] div_req [ND];
   logic [NG-1:0] g_in, g_en, g_out;
   logic irq_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   logic wr_pcc, wr_sys;
   assign wr_pcc = bus_req.wr && hit(bus_req.addr, `DTCD_OFF_PCC);
   assign wr_sys = bus_req.wr && hit(bus_req.addr, `DTCD_OFF_SYS);

   // global reset period timer guards the source clock bypass bit
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rst_cnt_reg <= 16'h0;
      else if (!rst_done)
         rst_cnt_reg <= rst_cnt_reg + 16'h1;
   end
   assign rst_done = (rst_cnt_reg >= 16'(GLOBAL_RESET_CYCLES));

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pcc_reg <= `DTCD_RST_PCC;
      else if (wr_pcc)
      begin
         pcc_reg <= bus_req.wdata[15:0];
         if (!rst_done)
            pcc_reg[`DTCD_PCC_BYPASS] <= pcc_reg[`DTCD_PCC_BYPASS];
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dcc_reg <= `DTCD_RST_DCC;
         die1_reg <= `DTCD_RST_DIE1;
         die2_reg <= `DTCD_RST_DIE2;
         pie1_reg <= `DTCD_RST_PIE1;
         pie2_reg <= `DTCD_RST_PIE2;
         pwr_reg <= `DTCD_RST_PWR;
         pmux_reg <= `DTCD_RST_PMUX;
      end
      else if (bus_req.wr)
      begin
         if (hit(bus_req.addr, `DTCD_OFF_DCC))
            dcc_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_DIE1))
            die1_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_DIE2))
            die2_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_PIE1))
            pie1_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_PIE2))
            pie2_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_PWR))
            pwr_reg <= bus_req.wdata[15:0];
         if (hit(bus_req.addr, `DTCD_OFF_PMUX))
            pmux_reg <= bus_req.wdata[15:0];
      end
   end

   // reserved scheme codes are dropped, the old scheme stays
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         scheme_reg <= `DTCD_SCHEME_SYNC;
      else if (wr_sys && (bus_req.wdata[2:0] == `DTCD_SCHEME_SYNC
                          || bus_req.wdata[2:0] == `DTCD_SCHEME_SCALABLE))
         scheme_reg <= bus_req.wdata[2:0];
   end

   // sources: toggles of mclk give exact 50 percent duty
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dsp_pll_reg <= 1'b0;
         tr_src_reg <= 1'b0;
         dsp_src_reg <= 1'b0;
      end
      else
      begin
         dsp_pll_reg <= ~dsp_pll_reg;
         tr_src_reg <= ~tr_src_reg;
         // registered mux; switching bypass may stretch one phase
         dsp_src_reg <= pcc_reg[`DTCD_PCC_BYPASS] ? reference_input_clock
                                                   : dsp_pll_reg;
      end
   end

   // watchdog: reference over 14 as a 7-high 7-low square
   assign ref_rise = reference_input_clock & ~ref_q;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ref_q <= 1'b0;
         wd_cnt_reg <= 3'h0;
         wd14_reg <= 1'b0;
      end
      else
      begin
         ref_q <= reference_input_clock;
         if (ref_rise)
         begin
            if (wd_cnt_reg == `DTCD_WD_HALF)
            begin
               wd_cnt_reg <= 3'h0;
               wd14_reg <= ~wd14_reg;
            end
            else
               wd_cnt_reg <= wd_cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dsp_src_q <= 1'b0;
         tmr_half_reg <= 1'b0;
      end
      else
      begin
         dsp_src_q <= dsp_src_reg;
         if (dsp_src_reg && !dsp_src_q)
            tmr_half_reg <= ~tmr_half_reg;
      end
   end

   always_comb
   begin
      div_src = {tr_src_reg, tr_src_reg, dsp_src_reg, dsp_src_reg,
                 dsp_src_reg, dsp_src_reg};
      div_req[D_CORE] = pcc_reg[`DTCD_PCC_DSP_CORE_DIVIDER +: 2];
      div_req[D_MM] = pcc_reg[`DTCD_PCC_MMDIV +: 2];
      div_req[D_GPIO] = dcc_reg[`DTCD_DCC_PIN_IO_DIVIDER +: 2];
      div_req[D_PER] = dcc_reg[`DTCD_DCC_PERDIV +: 2];
      div_req[D_TC] = pcc_reg[`DTCD_PCC_TRAFFIC_CTRL_DIVIDER +: 2];
      div_req[D_DISP] = pcc_reg[`DTCD_PCC_DISPDIV +: 2];
   end

   genvar d;
   generate
      for (d = 0; d < ND; d = d + 1)
      begin : g_div
         dtcd_divider u_div (
            .mclk(mclk),
            .rst(rst),
            .src(div_src[d]),
            .ratio_req(div_req[d]),
            .clk_out(div_clk[d]),
            .ratio_cur(),
            .busy(div_busy[d])
         );
      end
   endgenerate

   logic if_idle;
   assign if_idle = pie1_reg[`DTCD_PIE1_IF];

   always_comb
   begin
      g_in = '0;
      g_en = '0;
      g_in[G_CORE] = div_clk[D_CORE];
      g_en[G_CORE] = pcc_reg[`DTCD_PCC_COREEN] || !dsp_in_reset;
      g_in[G_MM] = div_clk[D_MM];
      g_en[G_MM] = 1'b1;
      g_in[G_GPIO] = dcc_reg[`DTCD_DCC_PIN_IO_SOURCE_SELECT] ? reference_input_clock
                                               : div_clk[D_GPIO];
      g_en[G_GPIO] = die2_reg[`DTCD_DIE2_GPIO];
      g_in[G_PUB] = reference_input_clock;
      g_en[G_PUB] = die2_reg[`DTCD_DIE2_PUB] && !die1_reg[`DTCD_DIE1_PUB];
      g_in[G_TIM] = dcc_reg[`DTCD_DCC_TIMXO] ? reference_input_clock
                                              : tmr_half_reg;
      g_en[G_TIM] = die2_reg[`DTCD_DIE2_TIM] && !die1_reg[`DTCD_DIE1_TIM];
      g_in[G_WD] = wd14_reg;
      g_en[G_WD] = watchdog_mode || (die2_reg[`DTCD_DIE2_WD]
                                     && !die1_reg[`DTCD_DIE1_WD]);
      g_in[G_PER] = div_clk[D_PER];
      g_en[G_PER] = 1'b1;
      g_in[G_TC] = div_clk[D_TC];
      g_en[G_TC] = !if_idle;
      g_in[G_LB] = div_clk[D_TC];
      g_en[G_LB] = pie2_reg[`DTCD_PIE2_LB] && !pie1_reg[`DTCD_PIE1_LB];
      g_in[G_HP] = div_clk[D_TC];
      g_en[G_HP] = !(pie1_reg[`DTCD_PIE1_HP] && dsp_idle);
      g_in[G_DMA] = div_clk[D_TC];
      g_en[G_DMA] = pie2_reg[`DTCD_PIE2_DMA] && !if_idle;
      g_in[G_BR] = div_clk[D_TC];
      g_en[G_BR] = !if_idle;
      g_in[G_DISP] = div_clk[D_DISP];
      g_en[G_DISP] = pie2_reg[`DTCD_PIE2_DISP] && !pie1_reg[`DTCD_PIE1_DISP];
   end

   dtcd_gate #(.N(NG)) u_gate (
      .mclk(mclk),
      .rst(rst),
      .clk_in(g_in),
      .en(g_en),
      .clk_out(g_out)
   );

   assign dsp_core_clock = g_out[G_CORE];
   assign dsp_memmgmt_clock = g_out[G_MM];
   assign dsp_pin_io_clock = g_out[G_GPIO];
   assign dsp_public_periph_clock = g_out[G_PUB];
   assign dsp_timer_clock = g_out[G_TIM];
   assign dsp_watchdog_clock = g_out[G_WD];
   assign dsp_periph_clock = g_out[G_PER];
   assign traffic_ctrl_clock = g_out[G_TC];
   assign local_bus_clock = g_out[G_LB];
   assign host_port_clock = g_out[G_HP];
   assign system_dma_clock = g_out[G_DMA];
   assign periph_bridge_clock = g_out[G_BR];
   assign display_ctrl_clock = g_out[G_DISP];
   assign irq_handler_clock = irq_q;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= pcc_reg[`DTCD_PCC_IRQSEL] ? g_out[G_TC]
                                           : processor_core_clock;
   end

   // fifo bypass, low power request and its ball
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fifo_bypass_tc_proc <= 1'b1;
         fifo_bypass_tc_dspmm <= 1'b1;
         low_power_request <= 1'b0;
         shared_io_ball <= '0;
      end
      else
      begin
         fifo_bypass_tc_proc <= (scheme_reg == `DTCD_SCHEME_SYNC);
         fifo_bypass_tc_dspmm <= (scheme_reg == `DTCD_SCHEME_SYNC);
         low_power_request <= deep_sleep || pwr_reg[`DTCD_PWR_LP];
         shared_io_ball.oe <= (pmux_reg[`DTCD_PMUX_LSB +: 3] == `DTCD_PMUX_LP);
         shared_io_ball.out <= (deep_sleep || pwr_reg[`DTCD_PWR_LP])
                               && (pmux_reg[`DTCD_PMUX_LSB +: 3] == `DTCD_PMUX_LP);
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         bus_rdata <= 32'h0;
      else if (bus_req.rd)
      begin
         unique case (bus_req.addr)
            `DTCD_OFF_PCC: bus_rdata <= {16'h0, pcc_reg};
            `DTCD_OFF_DCC: bus_rdata <= {16'h0, dcc_reg};
            `DTCD_OFF_DIE1: bus_rdata <= {16'h0, die1_reg};
            `DTCD_OFF_DIE2: bus_rdata <= {16'h0, die2_reg};
            `DTCD_OFF_PIE1: bus_rdata <= {16'h0, pie1_reg};
            `DTCD_OFF_PIE2: bus_rdata <= {16'h0, pie2_reg};
            `DTCD_OFF_PWR: bus_rdata <= {16'h0, pwr_reg};
            `DTCD_OFF_SYS: bus_rdata <= {29'h0, scheme_reg};
            `DTCD_OFF_PMUX: bus_rdata <= {16'h0, pmux_reg};
            `DTCD_OFF_STAT: bus_rdata <= {10'h0, rst_done, low_power_request,
                                          fifo_bypass_tc_proc, div_busy, g_out};
            default: bus_rdata <= 32'h0;
         endcase
      end
      else
         bus_rdata <= 32'h0;
   end

   property p_bypass;
      @(posedge mclk) disable iff (rst)
      (scheme_reg == `DTCD_SCHEME_SCALABLE) |=> !fifo_bypass_tc_proc && !fifo_bypass_tc_dspmm;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("fifo bypassed in scalable scheme");
   property p_scheme_refuse;
      @(posedge mclk) disable iff (rst)
      (wr_sys && bus_req.wdata[2:0] != 3'h0 && bus_req.wdata[2:0] != 3'h2)
         |=> $stable(scheme_reg);
   endproperty
   a_scheme_refuse: assert property (p_scheme_refuse)
      else $error("reserved scheme code accepted");
   property p_lp_sleep;
      @(posedge mclk) disable iff (rst)
      deep_sleep |=> low_power_request;
   endproperty
   a_lp_sleep: assert property (p_lp_sleep)
      else $error("no low power request in deep sleep");
   property p_ball_mux;
      @(posedge mclk) disable iff (rst)
      (pmux_reg[14:12] != 3'h1) |=> !shared_io_ball.oe && !shared_io_ball.out;
   endproperty
   a_ball_mux: assert property (p_ball_mux)
      else $error("ball driven without mux code");
   property p_bypass_locked;
      @(posedge mclk) disable iff (rst)
      (wr_pcc && !rst_done) |=> $stable(pcc_reg[`DTCD_PCC_BYPASS]);
   endproperty
   a_bypass_locked: assert property (p_bypass_locked)
      else $error("source bypass changed inside reset period");
   property p_div_reset;
      @(posedge mclk) disable iff (rst)
      $fell(rst) |-> dcc_reg[3:0] == 4'h0 && pcc_reg[1:0] == 2'h0;
   endproperty
   a_div_reset: assert property (p_div_reset)
      else $error("dividers not at divide by 1 after reset");
   property p_wd_mode;
      @(posedge mclk) disable iff (rst)
      ($rose(wd14_reg) && watchdog_mode && $past(watchdog_mode)) |=> dsp_watchdog_clock;
   endproperty
   a_wd_mode: assert property (p_wd_mode)
      else $error("watchdog clock stopped in watchdog mode");
endmodule : dtcd_clock_distribution
`default_nettype wire

// [verification/dtcd_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dtcd_far_model
(
   input wire logic mclk,
   input wire logic rst,
   output logic reference_input_clock,
   output logic processor_core_clock
);
   logic [1:0] ref_cnt_reg;
   // reference runs at an eighth of mclk, free even in reset
   always @(posedge mclk)
   begin
      ref_cnt_reg <= ref_cnt_reg + 2'h1;
      if (ref_cnt_reg == 2'h3)
         reference_input_clock <= ~reference_input_clock;
   end
   // processor clock at top rate, so traffic never outruns it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         processor_core_clock <= 1'b0;
      else
         processor_core_clock <= ~processor_core_clock;
   end
   initial
   begin
      ref_cnt_reg = 2'h0;
      reference_input_clock = 1'b0;
   end
endmodule : dtcd_far_model
`default_nettype wire

// [verification/tb_dtcd_clock_distribution.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_dtcd_clock_distribution;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   dtcd_pkg::dtcd_bus_req_t bus_req = '0;
   dtcd_pkg::dtcd_ball_t shared_io_ball;
   logic [31:0] bus_rdata;
   logic ref_clk, proc_clk, lp;
   logic dsp_in_reset = 1'b0, dsp_idle = 1'b0, watchdog_mode = 1'b0, deep_sleep = 1'b0;
   logic byp_proc, byp_mm;
   wire [13:0] ck;
   int num_errors = 0, check_count = 0, n;
   always #50 mclk = ~mclk;
   dtcd_far_model far_u (.mclk(mclk), .rst(rst), .reference_input_clock(ref_clk),
      .processor_core_clock(proc_clk));
   dtcd_clock_distribution dut_u (.mclk(mclk), .rst(rst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .reference_input_clock(ref_clk), .processor_core_clock(proc_clk),
      .dsp_in_reset(dsp_in_reset), .dsp_idle(dsp_idle), .watchdog_mode(watchdog_mode),
      .deep_sleep(deep_sleep), .dsp_core_clock(ck[0]), .dsp_memmgmt_clock(ck[4]),
      .dsp_pin_io_clock(ck[5]), .dsp_public_periph_clock(ck[6]), .dsp_timer_clock(ck[7]),
      .dsp_watchdog_clock(ck[3]), .dsp_periph_clock(ck[8]), .traffic_ctrl_clock(ck[1]),
      .local_bus_clock(ck[9]), .host_port_clock(ck[2]), .system_dma_clock(ck[10]),
      .periph_bridge_clock(ck[11]), .display_ctrl_clock(ck[12]), .irq_handler_clock(ck[13]),
      .fifo_bypass_tc_proc(byp_proc), .fifo_bypass_tc_dspmm(byp_mm),
      .low_power_request(lp), .shared_io_ball(shared_io_ball));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(negedge mclk);
      chk("rdata", exp, bus_rdata);
   endtask : rd
   // counts rising edges of one watched clock, settling first after a change
   task automatic rises(input int idx, input int cyc, output int cnt);
      logic [13:0] v, p;
      cnt = 0;
      repeat (40) @(negedge mclk);
      p = ck;
      repeat (cyc)
      begin
         @(negedge mclk);
         v = ck;
         if (v[idx] === 1'b1 && p[idx] === 1'b0)
            cnt++;
         p = v;
      end
      // hand back on a rising edge so later stimulus lands there
      @(posedge mclk);
   endtask : rises
   task automatic ticks(input string name, input int idx, input int cyc, input int lo,
                        input int hi);
      int c;
      rises(idx, cyc, c);
      chk(name, 32'h1, {31'h0, c >= lo && c <= hi});
   endtask : ticks
   task automatic test_regs;
      @(negedge mclk);
      chk("bypass", 32'h1, {31'h0, byp_proc & byp_mm});
      // bypass clear attempted inside the reset period must not stick
      wr(8'h00, 32'h0100);
      rd(8'h00, 32'h0000_0500);
      rd(8'h04, 32'h0);
      rd(8'h3c, 32'h0);
   endtask : test_regs
   task automatic test_scheme;
      wr(8'h1c, 32'h2);
      wr(8'h1c, 32'h1);
      rd(8'h1c, 32'h2);
      chk("fifo_used", 32'h0, {31'h0, byp_proc | byp_mm});
      wr(8'h1c, 32'h0);
      repeat (2) @(negedge mclk);
      chk("fifo_bypass", 32'h1, {31'h0, byp_proc & byp_mm});
   endtask : test_scheme
   task automatic test_low_power;
      wr(8'h18, 32'h2);
      repeat (2) @(negedge mclk);
      chk("lp_soft", 32'h1, {31'h0, lp});
      chk("ball_off", 32'h0, {31'h0, shared_io_ball.oe});
      wr(8'h20, 32'h1000);
      repeat (2) @(negedge mclk);
      chk("ball_on", 32'h3, {30'h0, shared_io_ball.oe, shared_io_ball.out});
      wr(8'h18, 32'h0);
      deep_sleep <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("lp_sleep", 32'h1, {31'h0, lp});
      @(posedge mclk);
      deep_sleep <= 1'b0;
   endtask : test_low_power
   task automatic test_clocks;
      dsp_in_reset <= 1'b1;
      wr(8'h00, 32'h0400);
      rises(0, 64, n);
      chk("core_stopped", 32'h0, n);
      dsp_in_reset <= 1'b0;
      rises(0, 64, n);
      chk("core_runs", 32'h1, {31'h0, n > 0});
      wr(8'h00, 32'h0500);
      rises(1, 160, n);
      chk("tc_div1", 32'h1, {31'h0, n >= 78 && n <= 81});
      wr(8'h00, 32'h0530);
      rises(1, 160, n);
      chk("tc_div8", 32'h1, {31'h0, n >= 9 && n <= 11});
      wr(8'h10, 32'h1);
      rises(1, 64, n);
      chk("tc_idle", 32'h0, n);
      wr(8'h10, 32'h4);
      rises(2, 64, n);
      chk("host_runs", 32'h1, {31'h0, n > 0});
      dsp_idle <= 1'b1;
      rises(2, 64, n);
      chk("host_stops", 32'h0, n);
      watchdog_mode <= 1'b1;
      rises(3, 300, n);
      chk("wd_forced", 32'h1, {31'h0, n > 0});
      watchdog_mode <= 1'b0;
      rises(3, 300, n);
      chk("wd_off", 32'h0, n);
   endtask : test_clocks
   // enters with traffic clocks at /8, host idle, dsp idle, watchdog mode off
   task automatic test_gates;
      ticks("mm_on", 4, 64, 7, 9);
      ticks("per_on", 8, 64, 7, 9);
      ticks("gpio_off", 5, 64, 0, 0);
      ticks("core_div1", 0, 160, 19, 21);
      wr(8'h00, 32'h0531);
      ticks("core_div2", 0, 160, 9, 11);
      wr(8'h0c, 32'hf);
      ticks("gpio_on", 5, 64, 7, 9);
      ticks("pub_on", 6, 64, 7, 9);
      ticks("tim_on", 7, 64, 3, 5);
      ticks("wd_on", 3, 300, 2, 3);
      wr(8'h08, 32'h7);
      ticks("pub_idle", 6, 64, 0, 0);
      ticks("tim_idle", 7, 64, 0, 0);
      ticks("wd_idle", 3, 300, 0, 0);
      ticks("lb_off", 9, 64, 0, 0);
      wr(8'h14, 32'h7);
      ticks("lb_on", 9, 64, 3, 5);
      ticks("dma_on", 10, 64, 3, 5);
      ticks("br_on", 11, 64, 3, 5);
      ticks("disp_on", 12, 64, 31, 33);
      ticks("irq_proc", 13, 64, 31, 33);
      wr(8'h10, 32'h5);
      ticks("dma_idle", 10, 64, 0, 0);
      ticks("br_idle", 11, 64, 0, 0);
      wr(8'h00, 32'h0731);
      ticks("irq_tc", 13, 64, 0, 0);
   endtask : test_gates
   task automatic print_verdict;
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      test_regs();
      test_scheme();
      test_low_power();
      test_clocks();
      test_gates();
      print_verdict();
   end
   initial
   begin
      #1000000;
      num_errors++;
      print_verdict();
   end
endmodule : tb_dtcd_clock_distribution
`default_nettype wire
